// ==== design/ive_pkg.sv ====
/*
 * Constants shared by the command interpreter for interrupt vectors,
 * interrupt return, user functions and position-reached events.
 * Assumes byte-wide command fields and a 32-bit value field.
 */
package ive_pkg;
    localparam int unsigned NUM_MOTORS     = 6;
    localparam int unsigned VEC_DEPTH      = 256;
    // opcodes
    localparam logic [7:0]  OP_VECTOR      = 8'h25;
    localparam logic [7:0]  OP_IRQ_RETURN  = 8'h26;
    localparam logic [7:0]  OP_USER_FIRST  = 8'h40;
    localparam logic [7:0]  OP_USER_LAST   = 8'h47;
    localparam logic [7:0]  OP_POS_EVENT   = 8'h8a;
    // reply status codes
    localparam logic [7:0]  ST_OK          = 8'h64;
    localparam logic [7:0]  ST_POS_REACHED = 8'h80;
    localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
    // type field of the position-event request
    localparam logic [7:0]  EVT_ONE_SHOT   = 8'h00;
    localparam logic [7:0]  EVT_PERSIST    = 8'h01;
    // reset values and default reply addresses
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;
    localparam logic [7:0]  DEF_MODULE_ADR = 8'h01;
    localparam logic [7:0]  DEF_HOST_ADR   = 8'h02;
endpackage

// ==== design/ive_evt_if.sv ====
/*
 * Carrier between the command decoder and the position event tracker.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ive_evt_if;
    logic       arm;
    logic       persist;
    logic [7:0] mask;
    logic       mvp_start;
    logic [2:0] mvp_motor;
    logic [5:0] reached;
    logic       fire;
    logic [7:0] fire_mask;
    modport ctrl    (output arm, persist, mask, mvp_start, mvp_motor, reached, input fire, fire_mask);
    modport tracker (input arm, persist, mask, mvp_start, mvp_motor, reached, output fire, fire_mask);
endinterface

// ==== design/ive_pos_tracker.sv ====
/*
 * Tracks which motors owe a position-reached notice.
 * Assumes move starts and reached pulses come from logic on clk.
 */
`timescale 1ns/1ps
module ive_pos_tracker
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // decoder side
    ive_evt_if.tracker evt
);
    import ive_pkg::*;

    logic                  active_r;
    logic                  persist_r;
    logic [7:0]            mask_r;
    logic [NUM_MOTORS-1:0] watch_r;
    logic [NUM_MOTORS-1:0] hit;
    logic                  fire_r;
    logic [7:0]            fire_mask_r;
    logic                  mvp_sel;

    assign mvp_sel       = evt.mvp_start & active_r & mask_r[evt.mvp_motor];
    assign evt.fire      = fire_r;
    assign evt.fire_mask = fire_mask_r;

    genvar m;
    generate
        for (m = 0; m < NUM_MOTORS; m++)
        begin : g_motor
            logic set_w;
            assign set_w  = mvp_sel & (evt.mvp_motor == 3'(m));
            assign hit[m] = evt.reached[m] & watch_r[m];
            always_ff @(posedge clk)
            begin
                if (reset)
                    watch_r[m] <= 1'b0;
                else if (set_w)
                    watch_r[m] <= 1'b1; // set wins over reached
                else if (hit[m])
                    watch_r[m] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            active_r  <= 1'b0;
            persist_r <= 1'b0;
            mask_r    <= RST_BYTE;
        end
        else if (evt.arm)
        begin
            active_r  <= 1'b1;
            persist_r <= evt.persist;
            mask_r    <= evt.mask;
        end
        else if (mvp_sel && !persist_r)
            active_r  <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            fire_r      <= 1'b0;
            fire_mask_r <= RST_BYTE;
        end
        else
        begin
            fire_r      <= |hit;
            fire_mask_r <= mask_r;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    one_shot_a: assert property (mvp_sel && !persist_r && !evt.arm |=> !active_r)
        else $error("one-shot request not consumed by first move");
    persist_keep_a: assert property (mvp_sel && persist_r && !evt.arm |=> active_r)
        else $error("persistent request dropped after a move");
    fire_cause_a: assert property (evt.fire |-> $past(|hit))
        else $error("position event without a watched motor reaching target");
endmodule

// ==== design/ive_cmd_top.sv ====
/*
 * Command interpreter for interrupt vector definition, interrupt return,
 * user function opcodes and the position-reached event request.
 * Assumes a decoded command frame arrives in parallel with valid/ready,
 * the reply frame leaves in parallel with valid/ready, and all motion
 * and program-engine signals share clk.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - vector opcode stores handler address per interrupt
// - return opcode restores saved accumulator, x, flags, pc
// - eight user opcodes reply 100, user value
// - event request: immediate reply, later reached reply
// - event request accepted only in direct mode
// - value field is motor mask, bit n
// - type 0 next move only; 1 every move
// - immediate reply status 64h, mask in byte0
// - reached reply status 80h, mask in byte0
module ive_cmd_top
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // command frame in
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_program,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [7:0]  cmd_type,
    input  wire logic [7:0]  cmd_bank,
    input  wire logic [31:0] cmd_value,
    // reply frame out
    output logic             rep_valid,
    input  wire logic        rep_ready,
    output logic [7:0]       rep_module_adr,
    output logic [7:0]       rep_host_adr,
    output logic [7:0]       rep_status,
    output logic [7:0]       rep_cmd,
    output logic [31:0]      rep_value,
    output logic [7:0]       rep_checksum,
    // user functions
    input  wire logic [31:0] uf_result,
    output logic             uf_strobe,
    output logic [2:0]       uf_index,
    output logic [7:0]       uf_type,
    output logic [7:0]       uf_bank,
    output logic [31:0]      uf_value,
    // program engine context
    input  wire logic        irq_take,
    input  wire logic [31:0] ctx_acc,
    input  wire logic [31:0] ctx_x,
    input  wire logic [7:0]  ctx_flags,
    input  wire logic [31:0] ctx_pc,
    output logic             restore_strobe,
    output logic [31:0]      restore_acc,
    output logic [31:0]      restore_x,
    output logic [7:0]       restore_flags,
    output logic [31:0]      restore_pc,
    // vector lookup
    input  wire logic [7:0]  vec_num,
    output logic [31:0]      vec_addr,
    // motion events
    input  wire logic        mvp_start,
    input  wire logic [2:0]  mvp_motor,
    input  wire logic [5:0]  pos_reached
);
    import ive_pkg::*;

    ive_evt_if evt ();

    ive_pos_tracker u_tracker
    (
        .clk   (clk),
        .reset (reset),
        .evt   (evt)
    );

    logic [31:0] vec_table [VEC_DEPTH];
    logic        cmd_ready_r, rep_valid_r, evt_pend_r, uf_strobe_r, restore_r;
    logic [7:0]  status_r, cmd_r, sum_r, uf_type_r, uf_bank_r, evt_mask_r;
    logic [31:0] value_r, uf_value_r, vec_addr_r;
    logic [2:0]  uf_index_r;
    logic [31:0] sv_acc_r, sv_x_r, sv_pc_r, rs_acc_r, rs_x_r, rs_pc_r;
    logic [7:0]  sv_flags_r, rs_flags_r;

    // decode
    logic cmd_take, is_vec, is_ret, is_user, is_evt, direct;
    logic imm_load, evt_load, rep_send, rep_valid_nxt, evt_pend_nxt;
    logic [7:0]  imm_status, ld_status, ld_cmd, ld_sum, evt_mask_nxt;
    logic [31:0] imm_value, ld_value;

    assign cmd_take = cmd_valid & cmd_ready_r;
    assign direct   = ~cmd_program;
    assign is_vec   = cmd_opcode == OP_VECTOR;
    assign is_ret   = cmd_opcode == OP_IRQ_RETURN;
    assign is_user  = (cmd_opcode >= OP_USER_FIRST) && (cmd_opcode <= OP_USER_LAST);
    assign is_evt   = cmd_opcode == OP_POS_EVENT;

    // stored programs get no reply; a request for events from one is dropped
    assign imm_load = cmd_take & direct;
    assign rep_send = rep_valid_r & rep_ready;
    assign evt_load = evt_pend_r & ~imm_load & (~rep_valid_r | rep_send);
    assign rep_valid_nxt = (rep_valid_r & ~rep_send) | imm_load | evt_load;
    assign evt_pend_nxt  = evt.fire | (evt_pend_r & ~evt_load); // set wins
    assign evt_mask_nxt  = evt.fire ? (evt_load ? evt.fire_mask : evt_mask_r | evt.fire_mask)
                         : (evt_load ? RST_BYTE : evt_mask_r);

    assign imm_status = (is_vec | is_ret | is_user | is_evt) ? ST_OK : ST_BAD_CMD;
    assign imm_value  = is_user ? uf_result
                      : is_evt ? {24'h00_0000, cmd_value[7:0]}
                      : RST_WORD;
    assign ld_status  = imm_load ? imm_status : ST_POS_REACHED;
    assign ld_cmd     = imm_load ? cmd_opcode : OP_POS_EVENT;
    assign ld_value   = imm_load ? imm_value : {24'h00_0000, evt_mask_r};
    assign ld_sum     = DEF_MODULE_ADR + DEF_HOST_ADR + ld_status + ld_cmd
                      + ld_value[31:24] + ld_value[23:16] + ld_value[15:8] + ld_value[7:0];

    assign evt.arm       = cmd_take & direct & is_evt;
    assign evt.persist   = cmd_type == EVT_PERSIST;
    assign evt.mask      = cmd_value[7:0];
    assign evt.mvp_start = mvp_start;
    assign evt.mvp_motor = mvp_motor;
    assign evt.reached   = pos_reached;

    assign cmd_ready      = cmd_ready_r;
    assign rep_valid      = rep_valid_r;
    assign rep_module_adr = DEF_MODULE_ADR;
    assign rep_host_adr   = DEF_HOST_ADR;
    assign rep_status     = status_r;
    assign rep_cmd        = cmd_r;
    assign rep_value      = value_r;
    assign rep_checksum   = sum_r;
    assign uf_strobe      = uf_strobe_r;
    assign uf_index       = uf_index_r;
    assign uf_type        = uf_type_r;
    assign uf_bank        = uf_bank_r;
    assign uf_value       = uf_value_r;
    assign restore_strobe = restore_r;
    assign restore_acc    = rs_acc_r;
    assign restore_x      = rs_x_r;
    assign restore_flags  = rs_flags_r;
    assign restore_pc     = rs_pc_r;
    assign vec_addr       = vec_addr_r;

    // vector table has no reset; it is undefined until written
    always_ff @(posedge clk)
    begin
        if (cmd_take && is_vec)
            vec_table[cmd_type] <= cmd_value;
        vec_addr_r <= vec_table[vec_num];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cmd_ready_r <= 1'b0;
            rep_valid_r <= 1'b0;
            evt_pend_r  <= 1'b0;
            evt_mask_r  <= RST_BYTE;
        end
        else
        begin
            cmd_ready_r <= ~rep_valid_nxt;
            rep_valid_r <= rep_valid_nxt;
            evt_pend_r  <= evt_pend_nxt;
            evt_mask_r  <= evt_mask_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            status_r <= RST_BYTE;
            cmd_r    <= RST_BYTE;
            value_r  <= RST_WORD;
            sum_r    <= RST_BYTE;
        end
        else if (imm_load || evt_load)
        begin
            status_r <= ld_status;
            cmd_r    <= ld_cmd;
            value_r  <= ld_value;
            sum_r    <= ld_sum;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            uf_strobe_r <= 1'b0;
            uf_index_r  <= 3'h0;
            uf_type_r   <= RST_BYTE;
            uf_bank_r   <= RST_BYTE;
            uf_value_r  <= RST_WORD;
        end
        else
        begin
            uf_strobe_r <= cmd_take & is_user;
            if (cmd_take && is_user)
            begin
                uf_index_r <= cmd_opcode[2:0];
                uf_type_r  <= cmd_type;
                uf_bank_r  <= cmd_bank;
                uf_value_r <= cmd_value;
            end
        end
    end

    // context saved on interrupt entry, handed back on return
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sv_acc_r   <= RST_WORD;
            sv_x_r     <= RST_WORD;
            sv_flags_r <= RST_BYTE;
            sv_pc_r    <= RST_WORD;
            restore_r  <= 1'b0;
            rs_acc_r   <= RST_WORD;
            rs_x_r     <= RST_WORD;
            rs_flags_r <= RST_BYTE;
            rs_pc_r    <= RST_WORD;
        end
        else
        begin
            if (irq_take)
            begin
                sv_acc_r   <= ctx_acc;
                sv_x_r     <= ctx_x;
                sv_flags_r <= ctx_flags;
                sv_pc_r    <= ctx_pc;
            end
            restore_r <= cmd_take & is_ret;
            if (cmd_take && is_ret)
            begin
                rs_acc_r   <= sv_acc_r;
                rs_x_r     <= sv_x_r;
                rs_flags_r <= sv_flags_r;
                rs_pc_r    <= sv_pc_r;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    vec_store_a: assert property (cmd_take && is_vec ##1 vec_num == $past(cmd_type)
                                  |=> vec_addr == $past(cmd_value, 2))
        else $error("vector table did not hold the stored handler address");
    ret_restore_a: assert property (cmd_take && is_ret |=> restore_strobe
                                    && restore_pc == $past(sv_pc_r) && restore_acc == $past(sv_acc_r)
                                    && restore_x == $past(sv_x_r) && restore_flags == $past(sv_flags_r))
        else $error("return did not restore saved context");
    ok_reply_a: assert property (cmd_take && direct && (is_vec || is_ret)
                                 |=> rep_valid && rep_status == ST_OK && rep_cmd == $past(cmd_opcode))
        else $error("vector or return reply not ok");
    user_reply_a: assert property (cmd_take && direct && is_user
                                   |=> uf_strobe && rep_value == $past(uf_result) && rep_status == ST_OK)
        else $error("user function reply wrong");
    prog_silent_a: assert property (cmd_take && cmd_program && !evt_load |=> !$rose(rep_valid))
        else $error("stored program command produced a reply");
    imm_evt_a: assert property (cmd_take && direct && is_evt |=> rep_status == ST_OK
                                && rep_cmd == OP_POS_EVENT && rep_value == {24'h00_0000, $past(cmd_value[7:0])})
        else $error("immediate event reply malformed");
    reached_reply_a: assert property (evt_load |=> rep_valid && rep_status == ST_POS_REACHED
                                      && rep_cmd == OP_POS_EVENT && rep_value[31:8] == 24'h00_0000)
        else $error("position reached reply malformed");
    evt_kept_a: assert property (evt.fire |=> evt_pend_r
                                 && (evt_mask_r & $past(evt.fire_mask)) == $past(evt.fire_mask))
        else $error("position event lost");
    ready_a: assert property (rep_valid && !rep_ready |=> rep_valid && $stable(rep_value) && !cmd_ready)
        else $error("reply changed while stalled");
endmodule

// ==== tb/ive_host_model.sv ====
/*
 * Host side of the frame interface: offers command frames and takes
 * reply frames, promptly or after a stall.
 * Assumes the block samples on the rising edge of clk.
 */
`timescale 1ns/1ps
module ive_host_model
(
    // clock
    input  wire logic        clk,
    // command frame
    output logic             cmd_valid,
    input  wire logic        cmd_ready,
    output logic             cmd_program,
    output logic [7:0]       cmd_opcode,
    output logic [7:0]       cmd_type,
    output logic [7:0]       cmd_bank,
    output logic [31:0]      cmd_value,
    // reply frame
    input  wire logic        rep_valid,
    output logic             rep_ready,
    input  wire logic [7:0]  rep_status,
    input  wire logic [7:0]  rep_cmd,
    input  wire logic [31:0] rep_value,
    input  wire logic [7:0]  rep_checksum
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_program = 1'b0;
        cmd_opcode = 8'hff;
        cmd_type = 8'hff;
        cmd_bank = 8'hff;
        cmd_value = 32'hffff_ffff;
        rep_ready = 1'b0;
    end

    task automatic send(input logic p, input logic [7:0] op, typ, bank, input logic [31:0] v, output bit ok);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_program = p;
        cmd_opcode = op;
        cmd_type = typ;
        cmd_bank = bank;
        cmd_value = v;
        ok = 1'b0;
        for (int n = 0; n < 60 && !ok; n++)
        begin
            @(posedge clk);
            ok = (cmd_ready === 1'b1);
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        // released fields flip so a late sample cannot pass
        cmd_program = ~p;
        cmd_opcode = ~op;
        cmd_type = ~typ;
        cmd_bank = ~bank;
        cmd_value = ~v;
    endtask

    task automatic get_reply(input int stall, output logic [7:0] st, cm, output logic [31:0] vl,
                             output logic [7:0] sm, output bit ok);
        repeat (stall + 1) @(negedge clk);
        rep_ready = 1'b1;
        ok = 1'b0;
        for (int n = 0; n < 60 && !ok; n++)
        begin
            @(posedge clk);
            ok = (rep_valid === 1'b1);
        end
        st = rep_status;
        cm = rep_cmd;
        vl = rep_value;
        sm = rep_checksum;
        @(negedge clk);
        rep_ready = 1'b0;
    endtask
endmodule

// ==== tb/ive_cmd_top_tb_top.sv ====
/*
 * Self-checking bench for the command interpreter.
 * Assumes the host model on the frame side; the bench drives program
 * engine and motion inputs at the falling edge.
 */
`timescale 1ns/1ps
module ive_cmd_top_tb_top;
    import ive_pkg::*;
    logic        clk, reset, cmd_valid, cmd_ready, cmd_program, rep_valid, rep_ready;
    logic        uf_strobe, irq_take, restore_strobe, mvp_start;
    logic [2:0]  uf_index, mvp_motor;
    logic [5:0]  pos_reached;
    logic [7:0]  cmd_opcode, cmd_type, cmd_bank, rep_module_adr, rep_host_adr, rep_status, rep_cmd;
    logic [7:0]  rep_checksum, uf_type, uf_bank, ctx_flags, restore_flags, vec_num;
    logic [31:0] cmd_value, rep_value, uf_result, uf_value, ctx_acc, ctx_x, ctx_pc;
    logic [31:0] restore_acc, restore_x, restore_pc, vec_addr;
    int          mismatches = 0, total_checks = 0, uf_hits = 0, rs_hits = 0;

    ive_cmd_top u_ive_cmd_top (.clk, .reset, .cmd_valid, .cmd_ready, .cmd_program, .cmd_opcode, .cmd_type,
        .cmd_bank, .cmd_value, .rep_valid, .rep_ready, .rep_module_adr, .rep_host_adr, .rep_status, .rep_cmd,
        .rep_value, .rep_checksum, .uf_result, .uf_strobe, .uf_index, .uf_type, .uf_bank, .uf_value, .irq_take,
        .ctx_acc, .ctx_x, .ctx_flags, .ctx_pc, .restore_strobe, .restore_acc, .restore_x, .restore_flags,
        .restore_pc, .vec_num, .vec_addr, .mvp_start, .mvp_motor, .pos_reached);
    ive_host_model u_ive_host_model (.clk, .cmd_valid, .cmd_ready, .cmd_program, .cmd_opcode, .cmd_type,
        .cmd_bank, .cmd_value, .rep_valid, .rep_ready, .rep_status, .rep_cmd, .rep_value, .rep_checksum);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // strobes must be single-cycle, so count every cycle seen high
    always @(negedge clk)
    begin
        if (uf_strobe === 1'b1) uf_hits++;
        if (restore_strobe === 1'b1) rs_hits++;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up;
        check("handshake", 32'h0, 32'h1);
        complete_run();
    endtask

    task automatic do_cmd(input logic p, input logic [7:0] op, typ, bank, input logic [31:0] v);
        bit ok;
        u_ive_host_model.send(p, op, typ, bank, v, ok);
        if (!ok) give_up();
    endtask

    task automatic reply(input int stall, input logic [7:0] es, ec, input logic [31:0] ev);
        logic [7:0]  st, cm, sm, sum;
        logic [31:0] vl;
        bit          ok;
        u_ive_host_model.get_reply(stall, st, cm, vl, sm, ok);
        if (!ok) give_up();
        check("module adr", rep_module_adr, DEF_MODULE_ADR);
        check("host adr", rep_host_adr, DEF_HOST_ADR);
        sum = DEF_MODULE_ADR + DEF_HOST_ADR + es + ec + ev[31:24] + ev[23:16] + ev[15:8] + ev[7:0];
        check("status", st, es);
        check("command", cm, ec);
        check("value", vl, ev);
        check("checksum", sm, sum);
    endtask

    task automatic silent(input int n);
        int hits;
        hits = 0;
        repeat (n) @(negedge clk) if (rep_valid !== 1'b0) hits++;
        check("no reply", hits, 0);
    endtask

    task automatic move(input logic [2:0] m);
        @(negedge clk);
        mvp_start = 1'b1;
        mvp_motor = m;
        @(negedge clk);
        mvp_start = 1'b0;
        repeat (2) @(negedge clk);
        pos_reached = 6'h01 << m;
        @(negedge clk);
        pos_reached = 6'h00;
    endtask

    task automatic s_vector;
        do_cmd(1'b0, OP_VECTOR, 8'hff, 8'h00, 32'h32);
        reply(0, ST_OK, OP_VECTOR, 32'h0);
        // lookup already points at the entry, so the store check sees the write
        vec_num = 8'h03;
        do_cmd(1'b1, OP_VECTOR, 8'h03, 8'h00, 32'h1234_5678);
        silent(4);
        vec_num = 8'hff;
        repeat (2) @(negedge clk);
        check("vec_addr ff", vec_addr, 32'h32);
        vec_num = 8'h03;
        repeat (2) @(negedge clk);
        check("vec_addr 03", vec_addr, 32'h1234_5678);
    endtask

    task automatic s_return;
        irq_take = 1'b1;
        ctx_acc = 32'h1111_2222;
        ctx_x = 32'h3333_4444;
        ctx_flags = 8'h5a;
        ctx_pc = 32'h0000_0077;
        @(negedge clk);
        irq_take = 1'b0;
        ctx_acc = ~ctx_acc;
        ctx_x = ~ctx_x;
        ctx_flags = ~ctx_flags;
        ctx_pc = ~ctx_pc;
        rs_hits = 0;
        do_cmd(1'b1, OP_IRQ_RETURN, 8'hff, 8'h00, 32'h0);
        repeat (3) @(negedge clk);
        check("restore_strobe", rs_hits, 1);
        check("restore_acc", restore_acc, 32'h1111_2222);
        check("restore_x", restore_x, 32'h3333_4444);
        check("restore_flags", restore_flags, 8'h5a);
        check("restore_pc", restore_pc, 32'h0000_0077);
        do_cmd(1'b0, OP_IRQ_RETURN, 8'hff, 8'h00, 32'h0);
        reply(0, ST_OK, OP_IRQ_RETURN, 32'h0);
    endtask

    task automatic s_user;
        for (int i = 0; i < 8; i++)
        begin
            uf_result = 32'hcafe_0000 + i;
            uf_hits = 0;
            do_cmd(1'b0, OP_USER_FIRST + 8'(i), 8'(i), 8'(i + 8), 32'h0bad_0000 + i);
            reply((i % 2) * 3, ST_OK, OP_USER_FIRST + 8'(i), 32'hcafe_0000 + i);
            check("uf_strobe", uf_hits, 1);
            check("uf_index", uf_index, i);
            check("uf_type", uf_type, i);
            check("uf_bank", uf_bank, i + 8);
            check("uf_value", uf_value, 32'h0bad_0000 + i);
        end
        // one past the user range is not a user function
        uf_hits = 0;
        do_cmd(1'b0, OP_USER_LAST + 8'h01, 8'h00, 8'h00, 32'h0);
        reply(0, ST_BAD_CMD, OP_USER_LAST + 8'h01, 32'h0);
        check("uf_strobe none", uf_hits, 0);
    endtask

    task automatic s_events;
        do_cmd(1'b1, OP_POS_EVENT, EVT_PERSIST, 8'h00, 32'h01);
        silent(3);
        move(3'd0);
        silent(8);
        do_cmd(1'b0, OP_POS_EVENT, EVT_PERSIST, 8'h00, 32'h05);
        reply(0, ST_OK, OP_POS_EVENT, 32'h05);
        move(3'd0);
        reply(0, ST_POS_REACHED, OP_POS_EVENT, 32'h05);
        repeat (2)
        begin
            move(3'd2);
            reply(2, ST_POS_REACHED, OP_POS_EVENT, 32'h05);
        end
        move(3'd1);
        silent(8);
        do_cmd(1'b0, OP_POS_EVENT, EVT_ONE_SHOT, 8'h00, 32'h08);
        reply(0, ST_OK, OP_POS_EVENT, 32'h08);
        move(3'd3);
        reply(0, ST_POS_REACHED, OP_POS_EVENT, 32'h08);
        move(3'd3);
        silent(8);
    endtask

    // reset in mid-run drops a held reply and disarms the tracker
    task automatic s_reset;
        do_cmd(1'b0, OP_POS_EVENT, EVT_PERSIST, 8'h00, 32'h3f);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        check("rep_valid in reset", rep_valid, 1'b0);
        check("cmd_ready in reset", cmd_ready, 1'b0);
        check("rep_status in reset", rep_status, 8'h00);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        check("rep_valid after reset", rep_valid, 1'b0);
        check("cmd_ready after reset", cmd_ready, 1'b1);
        move(3'd4);
        silent(8);
    endtask

    initial
    begin
        reset = 1'b1;
        irq_take = 1'b0;
        ctx_acc = 32'h0;
        ctx_x = 32'h0;
        ctx_flags = 8'h00;
        ctx_pc = 32'h0;
        vec_num = 8'h00;
        mvp_start = 1'b0;
        mvp_motor = 3'h0;
        pos_reached = 6'h00;
        uf_result = 32'h0;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        s_vector();
        s_return();
        s_user();
        s_events();
        s_reset();
        complete_run();
    end
endmodule
